// >>> rtl/tcmc_defines.svh
`ifndef TCMC_DEFINES_SVH
`define TCMC_DEFINES_SVH

// =====================================================================
// register offsets (byte addresses)
// =====================================================================
`define TCMC_OFS_MODE_CTL     12'h018
`define TCMC_OFS_COMPARE      12'h034
`define TCMC_OFS_STATUS       12'h040

// =====================================================================
// field positions of the mode control register
// =====================================================================
`define TCMC_DIR_LSB          0
`define TCMC_DIR_MSB          1
`define TCMC_FAST_BIT         2
`define TCMC_PRELOAD_BIT      3
`define TCMC_MODE_LSB         4
`define TCMC_MODE_MSB         6

// =====================================================================
// reset values and encodings
// =====================================================================
`define TCMC_MODE_CTL_RESET   16'h0000
`define TCMC_COMPARE_RESET    16'h0000
`define TCMC_DIR_OUTPUT       2'h0
`define TCMC_DIR_INPUT_ONE    2'h1
`define TCMC_DIR_INPUT_TWO    2'h2
`define TCMC_DIR_TRIGGER      2'h3
`define TCMC_MODE_FROZEN      3'h0
`define TCMC_MODE_MATCH_HIGH  3'h1
`define TCMC_MODE_MATCH_LOW   3'h2
`define TCMC_MODE_TOGGLE      3'h3
`define TCMC_MODE_FORCE_LOW   3'h4
`define TCMC_MODE_FORCE_HIGH  3'h5
`define TCMC_MODE_PWM_ONE     3'h6
`define TCMC_MODE_PWM_TWO     3'h7
`define TCMC_PROT_LOCK_ALL    2'h3

`endif

// >>> rtl/tcmc_pkg.sv
// =====================================================================
// shared types of the channel one mode control
// =====================================================================
package tcmc_pkg;
    typedef logic [1:0]  tcmc_dir_t;    // direction select field
    typedef logic [2:0]  tcmc_mode_t;   // compare mode field
    typedef logic [15:0] tcmc_count_t;  // counter and compare width
    typedef logic [11:0] tcmc_addr_t;   // apb address width
    typedef logic [31:0] tcmc_data_t;   // apb data width
endpackage

// >>> rtl/tcmc_compare_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcmc_defines.svh"

// =====================================================================
// compare value store: preload stage and active stage
// =====================================================================
module tcmc_compare_store
(
    input  wire logic                 i_clk,           // kernel clock
    input  wire logic                 i_reset_n,       // async reset, low
    input  wire logic                 i_wr_en,         // software write pulse
    input  wire tcmc_pkg::tcmc_count_t i_wr_data,      // written value
    input  wire logic                 i_preload_en,    // preload enable
    input  wire logic                 i_update_event,  // timer update event
    output var  tcmc_pkg::tcmc_count_t o_preload_value,// preload stage
    output var  tcmc_pkg::tcmc_count_t o_active_value  // value in use
);
    import tcmc_pkg::*;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // =================================================================
    // preload stage always takes the written value
    // =================================================================
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_preload_value <= `TCMC_COMPARE_RESET;
        else if (i_wr_en)
            o_preload_value <= i_wr_data;
    end

    // =================================================================
    // active stage: direct write or transfer at update
    // =================================================================
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_active_value <= `TCMC_COMPARE_RESET;
        else if (i_wr_en && !i_preload_en)
            o_active_value <= i_wr_data;
        else if (i_preload_en && i_update_event)
            o_active_value <= o_preload_value;
    end

    property p_direct_write;
        i_wr_en && !i_preload_en |=> o_active_value == $past(i_wr_data);
    endproperty
    a_direct_write: assert property (p_direct_write) else $error("direct compare write not applied");

    property p_preload_hold;
        i_preload_en && !i_update_event |=> $stable(o_active_value);
    endproperty
    a_preload_hold: assert property (p_preload_hold) else $error("active compare moved without update");
endmodule
`default_nettype wire

// >>> rtl/tcmc_channel_mode.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tcmc_defines.svh"

// =====================================================================
// channel one mode control with apb register access
// =====================================================================
module tcmc_channel_mode
(
    input  wire logic                  i_clk,                  // kernel clock
    input  wire logic                  i_reset_n,              // async reset, low
    // apb slave
    input  wire logic                  i_psel,                 // select
    input  wire logic                  i_penable,              // access phase
    input  wire logic                  i_pwrite,               // write direction
    input  wire tcmc_pkg::tcmc_addr_t  i_paddr,                // byte address
    input  wire tcmc_pkg::tcmc_data_t  i_pwdata,               // write data
    output var  tcmc_pkg::tcmc_data_t  o_prdata,               // read data
    output var  logic                  o_pready,               // transfer done
    output var  logic                  o_pslverr,              // unmapped address
    // timer context
    input  wire tcmc_pkg::tcmc_count_t i_counter_value,        // counter value
    input  wire logic                  i_count_tick,           // counter clock enable
    input  wire logic                  i_update_event,         // update event pulse
    input  wire logic                  i_ch1_channel_enable,   // channel enable bit
    input  wire logic [1:0]            i_protection_level,     // protection level
    input  wire logic                  i_single_pulse_enable,  // single pulse setting
    input  wire logic                  i_trigger_event,        // trigger input event
    input  wire logic                  i_timer_input_one,      // timer input one
    input  wire logic                  i_timer_input_two,      // timer input two
    input  wire logic                  i_internal_trigger_source, // internal trigger
    input  wire logic                  i_internal_trigger_active, // trigger input in use
    // results
    output var  logic                  o_ch1_compare_reference,// compare reference
    output var  logic                  o_ch1_is_output,        // channel is output
    output var  logic                  o_ch1_capture_input,    // selected capture source
    output var  tcmc_pkg::tcmc_count_t o_ch1_compare_value     // active compare value
);
    import tcmc_pkg::*;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // =================================================================
    // register fields
    // =================================================================
    tcmc_dir_t   ch1_direction_select_r;        // direction select
    logic        ch1_fast_response_enable_r;    // fast response enable
    logic        ch1_compare_preload_enable_r;  // preload enable
    tcmc_mode_t  ch1_compare_mode_r;            // compare mode
    logic [8:0]  mode_ctl_upper_r;              // bits 15:7 kept as storage
    tcmc_mode_t  prev_mode_r;                   // mode seen last cycle
    tcmc_count_t preload_value;                 // compare preload stage
    tcmc_count_t active_value;                  // compare value in use

    // =================================================================
    // apb decode
    // =================================================================
    logic wr_fire;        // write takes effect this edge
    logic rd_phase;       // first access cycle, answer prepared
    logic hit_mode;       // mode control address
    logic hit_compare;    // compare value address
    logic hit_status;     // status address
    logic mapped;         // any known address
    logic locked_prot;    // preload and mode locked
    tcmc_data_t rd_nxt;   // read mux result

    assign hit_mode    = (i_paddr == `TCMC_OFS_MODE_CTL);
    assign hit_compare = (i_paddr == `TCMC_OFS_COMPARE);
    assign hit_status  = (i_paddr == `TCMC_OFS_STATUS);
    assign mapped      = hit_mode || hit_compare || hit_status;
    assign rd_phase    = i_psel && i_penable && !o_pready;
    assign wr_fire     = i_psel && i_penable && o_pready && i_pwrite && mapped;
    assign locked_prot = (i_protection_level == `TCMC_PROT_LOCK_ALL) &&
                         (ch1_direction_select_r == `TCMC_DIR_OUTPUT);

    // =================================================================
    // read mux, reserved bits read zero
    // =================================================================
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (hit_mode)
            rd_nxt = {16'h0000, mode_ctl_upper_r, ch1_compare_mode_r,
                      ch1_compare_preload_enable_r,
                      ch1_fast_response_enable_r, ch1_direction_select_r};
        else if (hit_compare)
            rd_nxt = {16'h0000, preload_value};
        else if (hit_status)
            rd_nxt = {active_value, 13'h0000, i_single_pulse_enable,
                      o_ch1_is_output, o_ch1_compare_reference};
    end

    // =================================================================
    // apb handshake: one wait state, then ready with data
    // =================================================================
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end
        else if (rd_phase)
        begin
            o_pready  <= 1'b1;            // answer in next cycle
            o_pslverr <= !mapped;         // unmapped answered with error
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_nxt;
        end
        else
        begin
            o_pready  <= 1'b0;            // drop after completion
            o_pslverr <= 1'b0;
        end
    end

    // =================================================================
    // direction select, writable only while channel disabled
    // =================================================================
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            ch1_direction_select_r <= `TCMC_DIR_OUTPUT;
        else if (wr_fire && hit_mode && !i_ch1_channel_enable)
            ch1_direction_select_r <= i_pwdata[`TCMC_DIR_MSB:`TCMC_DIR_LSB];
    end

    // =================================================================
    // fast enable and upper storage, always writable
    // =================================================================
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ch1_fast_response_enable_r <= 1'b0;
            mode_ctl_upper_r           <= 9'h000;
        end
        else if (wr_fire && hit_mode)
        begin
            ch1_fast_response_enable_r <= i_pwdata[`TCMC_FAST_BIT];
            mode_ctl_upper_r           <= i_pwdata[15:7];
        end
    end

    // =================================================================
    // preload enable and compare mode, locked at level 3 as output
    // =================================================================
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ch1_compare_preload_enable_r <= 1'b0;
            ch1_compare_mode_r           <= `TCMC_MODE_FROZEN;
        end
        else if (wr_fire && hit_mode && !locked_prot)
        begin
            ch1_compare_preload_enable_r <= i_pwdata[`TCMC_PRELOAD_BIT];
            ch1_compare_mode_r           <= i_pwdata[`TCMC_MODE_MSB:`TCMC_MODE_LSB];
        end
    end

    // =================================================================
    // compare value stages
    // =================================================================
    tcmc_compare_store u_store
    (
        .i_clk           (i_clk),
        .i_reset_n       (i_reset_n),
        .i_wr_en         (wr_fire && hit_compare),
        .i_wr_data       (i_pwdata[15:0]),
        .i_preload_en    (ch1_compare_preload_enable_r),
        .i_update_event  (i_update_event),
        .o_preload_value (preload_value),
        .o_active_value  (active_value)
    );

    // =================================================================
    // direction decode and capture source selection
    // =================================================================
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_ch1_is_output     <= 1'b1;
            o_ch1_capture_input <= 1'b0;
            o_ch1_compare_value <= `TCMC_COMPARE_RESET;
        end
        else
        begin
            o_ch1_is_output     <= (ch1_direction_select_r == `TCMC_DIR_OUTPUT);
            o_ch1_compare_value <= active_value;
            case (ch1_direction_select_r)
                `TCMC_DIR_INPUT_ONE: o_ch1_capture_input <= i_timer_input_one;
                `TCMC_DIR_INPUT_TWO: o_ch1_capture_input <= i_timer_input_two;
                `TCMC_DIR_TRIGGER:   o_ch1_capture_input <= i_internal_trigger_active &&
                                                            i_internal_trigger_source;
                default:             o_ch1_capture_input <= 1'b0; // output: no capture
            endcase
        end
    end

    // =================================================================
    // compare reference generation
    // =================================================================
    logic is_match;      // counter equals compare
    logic below;         // counter below compare
    logic above;         // counter above compare
    logic pwm_entry;     // frozen to pwm change seen this cycle
    logic ref_nxt;       // next reference level

    assign is_match  = (i_counter_value == active_value);
    assign below     = (i_counter_value < active_value);
    assign above     = (i_counter_value > active_value);
    assign pwm_entry = (prev_mode_r == `TCMC_MODE_FROZEN) && ch1_compare_mode_r[2] &&
                       ch1_compare_mode_r[1];

    // previous mode tracker for the frozen to pwm transition
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            prev_mode_r <= `TCMC_MODE_FROZEN;
        else
            prev_mode_r <= ch1_compare_mode_r;
    end

    // next level per mode; match modes act on counter ticks only
    always_comb
    begin
        ref_nxt = o_ch1_compare_reference;
        case (ch1_compare_mode_r)
            `TCMC_MODE_FROZEN:     ref_nxt = o_ch1_compare_reference;
            `TCMC_MODE_MATCH_HIGH: if (i_count_tick && is_match)
                                       ref_nxt = 1'b1;
            `TCMC_MODE_MATCH_LOW:  if (i_count_tick && is_match)
                                       ref_nxt = 1'b0;
            `TCMC_MODE_TOGGLE:     if (i_count_tick && is_match)
                                       ref_nxt = !o_ch1_compare_reference;
            `TCMC_MODE_FORCE_LOW:  ref_nxt = 1'b0;
            `TCMC_MODE_FORCE_HIGH: ref_nxt = 1'b1;
            `TCMC_MODE_PWM_ONE:
            begin
                if (ch1_fast_response_enable_r && i_trigger_event)
                    ref_nxt = 1'b0;                  // act as if the match occurred
                else if (i_count_tick || pwm_entry)
                    ref_nxt = below;
            end
            `TCMC_MODE_PWM_TWO:
            begin
                if (ch1_fast_response_enable_r && i_trigger_event)
                    ref_nxt = 1'b1;                  // act as if the match occurred
                else if (i_count_tick || pwm_entry)
                    ref_nxt = above;
            end
            default:               ref_nxt = o_ch1_compare_reference;
        endcase
    end

    // reference register
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_ch1_compare_reference <= 1'b0;
        else
            o_ch1_compare_reference <= ref_nxt;
    end

    // =================================================================
    // checks
    // =================================================================
    property p_dir_lock;
        i_ch1_channel_enable |=> ch1_direction_select_r == $past(ch1_direction_select_r);
    endproperty
    a_dir_lock: assert property (p_dir_lock) else $error("direction changed while enabled");

    property p_prot_lock;
        locked_prot |=> $stable(ch1_compare_mode_r) && $stable(ch1_compare_preload_enable_r);
    endproperty
    a_prot_lock: assert property (p_prot_lock) else $error("locked fields changed");

    property p_output_flag;
        (ch1_direction_select_r == `TCMC_DIR_OUTPUT) [*2] |-> o_ch1_is_output;
    endproperty
    a_output_flag: assert property (p_output_flag) else $error("output flag wrong");

    property p_frozen;
        (ch1_compare_mode_r == `TCMC_MODE_FROZEN) ##1 (ch1_compare_mode_r == `TCMC_MODE_FROZEN)
            |-> $stable(o_ch1_compare_reference);
    endproperty
    a_frozen: assert property (p_frozen) else $error("frozen reference moved");

    property p_match_high;
        i_count_tick && is_match && ch1_compare_mode_r == `TCMC_MODE_MATCH_HIGH
            |=> o_ch1_compare_reference;
    endproperty
    a_match_high: assert property (p_match_high) else $error("match did not set reference");

    property p_match_low;
        i_count_tick && is_match && ch1_compare_mode_r == `TCMC_MODE_MATCH_LOW
            |=> !o_ch1_compare_reference;
    endproperty
    a_match_low: assert property (p_match_low) else $error("match did not clear reference");

    property p_toggle;
        i_count_tick && is_match && ch1_compare_mode_r == `TCMC_MODE_TOGGLE
            |=> o_ch1_compare_reference != $past(o_ch1_compare_reference);
    endproperty
    a_toggle: assert property (p_toggle) else $error("match did not toggle reference");

    property p_force;
        ch1_compare_mode_r == `TCMC_MODE_FORCE_LOW || ch1_compare_mode_r == `TCMC_MODE_FORCE_HIGH
            |=> o_ch1_compare_reference == $past(ch1_compare_mode_r == `TCMC_MODE_FORCE_HIGH);
    endproperty
    a_force: assert property (p_force) else $error("forced level wrong");

    property p_pwm_one;
        i_count_tick && !i_trigger_event && ch1_compare_mode_r == `TCMC_MODE_PWM_ONE
            |=> o_ch1_compare_reference == ($past(i_counter_value) < $past(active_value));
    endproperty
    a_pwm_one: assert property (p_pwm_one) else $error("pwm one level wrong");

    property p_pwm_entry;
        pwm_entry && !i_trigger_event
            |=> o_ch1_compare_reference == $past(ch1_compare_mode_r[0] ? above : below);
    endproperty
    a_pwm_entry: assert property (p_pwm_entry) else $error("pwm entry not evaluated");

    property p_pwm_two;
        i_count_tick && !i_trigger_event && ch1_compare_mode_r == `TCMC_MODE_PWM_TWO
            |=> o_ch1_compare_reference == ($past(i_counter_value) > $past(active_value));
    endproperty
    a_pwm_two: assert property (p_pwm_two) else $error("pwm two level wrong");

    property p_fast_trigger;
        ch1_fast_response_enable_r && i_trigger_event && ch1_compare_mode_r == `TCMC_MODE_PWM_ONE
            |=> !o_ch1_compare_reference;
    endproperty
    a_fast_trigger: assert property (p_fast_trigger) else $error("fast trigger did not act");

    property p_capture_one;
        ch1_direction_select_r == `TCMC_DIR_INPUT_ONE |=> o_ch1_capture_input == $past(i_timer_input_one);
    endproperty
    a_capture_one: assert property (p_capture_one) else $error("capture source one wrong");

    property p_capture_trigger;
        ch1_direction_select_r == `TCMC_DIR_TRIGGER
            |=> o_ch1_capture_input == $past(i_internal_trigger_active && i_internal_trigger_source);
    endproperty
    a_capture_trigger: assert property (p_capture_trigger) else $error("trigger capture source wrong");
endmodule
`default_nettype wire

// >>> bench/tcmc_channel_mode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// apb bench for the channel one mode control
// =====================================================================
module tcmc_channel_mode_tb_top;
    import tcmc_pkg::*;
    logic        clk, rst_n, psel, pen, pwr, tick, upd, en, trg, t1, t2, internal_trigger_source, act, spe, se;
    logic        pready, pslverr, ref_o, is_out, cap;
    logic [1:0]  prot;                  // protection level
    tcmc_addr_t  addr;                  // apb address
    tcmc_data_t  wdat, prdata, q;       // write data, read data, last read
    tcmc_count_t cnt, cmp;              // counter driven, active compare seen
    int          bad_count, compares;   // mismatches and comparisons
    // mode, counter and expected reference for each match step
    tcmc_mode_t  md [12] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h5, 3'h0, 3'h4, 3'h7, 3'h7, 3'h6, 3'h6};
    tcmc_count_t cv [12] = '{16'h4, 16'h5, 16'h5, 16'h5, 16'h5, 16'h4, 16'h5, 16'h4, 16'h9, 16'h2, 16'h2, 16'h9};
    logic [11:0] ex = 12'h56a;

    tcmc_channel_mode dut (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(addr), .i_pwdata(wdat), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_counter_value(cnt), .i_count_tick(tick), .i_update_event(upd), .i_ch1_channel_enable(en),
        .i_protection_level(prot), .i_single_pulse_enable(spe), .i_trigger_event(trg),
        .i_timer_input_one(t1), .i_timer_input_two(t2), .i_internal_trigger_source(internal_trigger_source),
        .i_internal_trigger_active(act), .o_ch1_compare_reference(ref_o), .o_ch1_is_output(is_out),
        .o_ch1_capture_input(cap), .o_ch1_compare_value(cmp));

    // verdict and end of run
    task end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input tcmc_data_t e, input tcmc_data_t a);
        compares++;
        if (a !== e)
        begin
            bad_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    // one apb transfer; starts after an edge so no signal is set twice per step
    task apb(input logic w, input tcmc_addr_t a, input tcmc_data_t d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        q  = prdata;
        se = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (n >= 16)
        begin
            bad_count++;
            end_sim();
        end
    endtask

    // one counter clock with the given counter value
    task step(input tcmc_count_t v);
        @(posedge clk);
        cnt  <= v;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        @(negedge clk);
    endtask

    // one-cycle pulse: trigger event when t is 1, update event when t is 0
    task pulse(input logic t);
        @(posedge clk);
        if (t)
            trg <= 1'b1;
        else
            upd <= 1'b1;
        @(posedge clk);
        trg <= 1'b0;
        upd <= 1'b0;
        repeat (2) @(negedge clk);
    endtask

    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        {rst_n, psel, pen, pwr, tick, upd, en, trg, t1, t2, internal_trigger_source, act, spe, prot} = '0;
        addr = '0;
        wdat = '0;
        cnt  = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, 12'h018, 0); chk(0, q);
        apb(0, 12'h07c, 0); chk(1, {31'h0, se}); chk(0, q);
        chk(1, {31'h0, is_out});
        $display("test reset done");
        apb(1, 12'h034, 5); repeat (2) @(negedge clk); chk(5, {16'h0, cmp});
        for (int i = 0; i < 12; i++)
        begin
            apb(1, 12'h018, {25'h0, md[i], 4'h0});
            step(cv[i]);
            chk({31'h0, ex[i]}, {31'h0, ref_o});
        end
        apb(1, 12'h018, 0); step(2); chk(0, {31'h0, ref_o});
        apb(1, 12'h018, 32'h60); repeat (2) @(negedge clk); chk(1, {31'h0, ref_o});
        apb(1, 12'h018, 32'h64); pulse(1'b1); chk(0, {31'h0, ref_o});
        $display("test modes done");
        apb(1, 12'h018, 32'h08); apb(1, 12'h034, 9);
        repeat (2) @(negedge clk); chk(5, {16'h0, cmp});
        pulse(1'b0); chk(9, {16'h0, cmp});
        apb(0, 12'h040, 0); chk(32'h0009_0002, q);
        $display("test preload done");
        @(posedge clk);
        prot <= 2'h3;
        apb(1, 12'h018, 32'h70); apb(0, 12'h018, 0); chk(32'h08, q);
        @(posedge clk);
        prot <= 2'h0;
        en   <= 1'b1;
        apb(1, 12'h018, 1); apb(0, 12'h018, 0); chk(0, q);
        @(posedge clk);
        {en, t1, internal_trigger_source, act} <= 4'h7;
        for (int d = 1; d < 4; d++)
        begin
            apb(1, 12'h018, d); repeat (2) @(negedge clk);
            chk(0, {31'h0, is_out}); chk({31'h0, d != 2}, {31'h0, cap});
        end
        $display("test direction done");
        end_sim();
    end
endmodule
`default_nettype wire
